// >>> verilog/cdm_consts.svh
/*
 * Fixed addresses, field positions and reset values of the call stack and
 * data memory block. Assumes it is included by bare name wherever needed.
 */
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

// ------------------------------------------------------------------
// sizes
// ------------------------------------------------------------------
`define CDM_PC_W 11
`define CDM_ADDR_W 7
`define CDM_NIB_W 4
`define CDM_MEM_DEPTH 128
`define CDM_SEG_COUNT 9
`define CDM_XFER_COUNT 4
`define CDM_SYNTH_W 16
`define CDM_PORTB_W 3

// ------------------------------------------------------------------
// data memory map
// ------------------------------------------------------------------
`define CDM_XFER_FIRST 7'h0C
`define CDM_GP_LAST 7'h60
`define CDM_SEG_FIRST 7'h61
`define CDM_SEG_LAST 7'h69
`define CDM_DISP_EN 7'h6A
`define CDM_SYN_MODE 7'h6B
`define CDM_CE_JDG 7'h6C
`define CDM_UNLK_JDG 7'h6D
`define CDM_BT0_JDG 7'h6E
`define CDM_BT1_JDG 7'h6F
`define CDM_PORT_A 7'h70
`define CDM_PORT_B 7'h71
`define CDM_PORT_C 7'h72
`define CDM_PORT_D 7'h73
`define CDM_SYS_FIRST 7'h74
`define CDM_SYS_LAST 7'h7D
`define CDM_FLAG_LO 7'h7E
`define CDM_FLAG_HI 7'h7F
`define CDM_WREG_ROW 3'h0

// peripheral address of the synthesizer division ratio
`define CDM_PERIPH_SYNTH 7'h41

// ------------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------------
`define CDM_FLAG_CMP 3
`define CDM_FLAG_CY 2
`define CDM_FLAG_Z 1
`define CDM_FLAG_BCD 0
`define CDM_JDG_BIT 0
`define CDM_NIB_ZERO 4'h0
`define CDM_PC_RESET 11'h000
`define CDM_PC_ONE 11'h001

`endif

// >>> verilog/cdm_pkg.sv
/*
 * Types of the call stack and data memory block: instruction codes and the
 * packed state record. Assumes cdm_consts.svh is on the include path.
 */
`include "cdm_consts.svh"

package cdm_pkg;

   // ------------------------------------------------------------------
   // memory instructions
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      CDM_OP_ADD,
      CDM_OP_ADD_CY,
      CDM_OP_SUB,
      CDM_OP_SUB_BW,
      CDM_OP_AND,
      CDM_OP_OR,
      CDM_OP_XOR,
      CDM_OP_LOAD,
      CDM_OP_STORE,
      CDM_OP_SK_EQ,
      CDM_OP_SK_GE,
      CDM_OP_SK_LT,
      CDM_OP_SK_NE,
      CDM_OP_SK_ALL,
      CDM_OP_SK_NONE
   } cdm_op_e;

   typedef logic [`CDM_NIB_W-1:0] cdm_nib_t;
   typedef logic [`CDM_ADDR_W-1:0] cdm_addr_t;

   // ------------------------------------------------------------------
   // whole state of the block
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [`CDM_MEM_DEPTH-1:0][`CDM_NIB_W-1:0] mem;
      logic [`CDM_PC_W-1:0] pc;
      logic [`CDM_PC_W-1:0] ret_addr;
      logic [`CDM_SYNTH_W-1:0] synth_div;
      logic [`CDM_NIB_W-1:0] pa_s1;
      logic [`CDM_NIB_W-1:0] pa_s2;
      logic [`CDM_PORTB_W-1:0] pb_s1;
      logic [`CDM_PORTB_W-1:0] pb_s2;
      logic ce_s1;
      logic ce_s2;
      logic ce_s3;
      logic [`CDM_NIB_W-1:0] result;
      logic skip;
      logic done;
   } cdm_state_s;

endpackage : cdm_pkg

// >>> verilog/cdm_core.sv
/*
 * Single-level return-address holder, program counter and the 128-nibble
 * data memory with its mapped peripheral, port, display and flag nibbles,
 * plus the nibble operation unit that executes the memory instructions.
 * Assumes: the instruction sequencer and peripherals run on sys_clk_i and
 * give one-cycle request pulses; port and enable pins are asynchronous.
 */
`include "cdm_consts.svh"

module cdm_core (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // program flow from the sequencer
   input wire logic pc_step_i,
   input wire logic branch_i,
   input wire logic call_i,
   input wire logic return_i,
   input wire logic [`CDM_PC_W-1:0] target_addr_i,
   input wire logic clock_stop_i,
   // memory instruction
   input wire logic exec_i,
   input wire cdm_pkg::cdm_op_e op_i,
   input wire logic imm_mode_i,
   input wire logic [2:0] mem_row_i,
   input wire logic [3:0] mem_col_i,
   input wire logic [3:0] wreg_col_i,
   input wire logic [`CDM_NIB_W-1:0] imm_i,
   // peripheral transfers
   input wire logic periph_put_i,
   input wire logic periph_get_i,
   input wire logic [`CDM_ADDR_W-1:0] periph_addr_i,
   input wire logic [`CDM_SYNTH_W-1:0] synth_div_rd_i,
   input wire logic synth_unlock_i,
   input wire logic btm0_carry_i,
   input wire logic btm1_carry_i,
   // pins
   input wire logic ce_pin_i,
   input wire logic [`CDM_NIB_W-1:0] port_a_pin_i,
   input wire logic [`CDM_PORTB_W-1:0] port_b_pin_i,
   // outputs
   output logic [`CDM_PC_W-1:0] pc_o,
   output logic [`CDM_NIB_W-1:0] result_o,
   output logic skip_o,
   output logic done_o,
   output logic [`CDM_SEG_COUNT*`CDM_NIB_W-1:0] segment_data_o,
   output logic [`CDM_NIB_W-1:0] display_enable_ctrl_o,
   output logic [`CDM_NIB_W-1:0] synth_mode_ctrl_o,
   output logic [`CDM_SYNTH_W-1:0] synth_div_o,
   output logic [`CDM_NIB_W-1:0] port_a_data_o,
   output logic [`CDM_NIB_W-1:0] port_c_data_o,
   output logic port_d_data_o,
   output logic [`CDM_NIB_W-1:0] flag_word_high_o,
   output logic flag_word_low_o
);

   // ------------------------------------------------------------------
   // address helpers
   // ------------------------------------------------------------------
   function automatic cdm_pkg::cdm_addr_t join_addr(
      input logic [2:0] row,
      input logic [3:0] col
   );
      join_addr = {row, col};
   endfunction : join_addr

   function automatic logic is_sys_dead(input cdm_pkg::cdm_addr_t a);
      is_sys_dead = (a >= `CDM_SYS_FIRST) && (a <= `CDM_SYS_LAST);
   endfunction : is_sys_dead

   // what an instruction sees when it reads a nibble
   function automatic cdm_pkg::cdm_nib_t read_view(
      input cdm_pkg::cdm_state_s s,
      input cdm_pkg::cdm_addr_t a
   );
      if (is_sys_dead(a)) begin
         read_view = `CDM_NIB_ZERO;
      end else if (a == `CDM_PORT_A) begin
         // pins 0 and 1 are the two-way lines, 2 and 3 read back the latch
         read_view = {s.mem[a][3:2], s.pa_s2[1:0]};
      end else if (a == `CDM_PORT_B) begin
         read_view = {1'b0, s.pb_s2};
      end else if (a == `CDM_FLAG_HI) begin
         read_view = {s.mem[a][3:1], 1'b0};
      end else begin
         read_view = s.mem[a];
      end
   endfunction : read_view

   // value that a write leaves behind at a given nibble
   function automatic cdm_pkg::cdm_nib_t write_view(
      input cdm_pkg::cdm_addr_t a,
      input cdm_pkg::cdm_nib_t v,
      input cdm_pkg::cdm_nib_t old
   );
      if (is_sys_dead(a) || a == `CDM_PORT_B || a == `CDM_CE_JDG) begin
         write_view = old;
      end else if (a == `CDM_FLAG_LO) begin
         write_view = {3'b000, v[`CDM_FLAG_BCD]};
      end else if (a == `CDM_FLAG_HI) begin
         write_view = {v[3:1], 1'b0};
      end else if (a >= `CDM_UNLK_JDG && a <= `CDM_BT1_JDG) begin
         write_view = {3'b000, v[`CDM_JDG_BIT]};
      end else if (a == `CDM_PORT_D) begin
         write_view = {3'b000, v[0]};
      end else begin
         write_view = v;
      end
   endfunction : write_view

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   cdm_pkg::cdm_state_s st_ff;
   cdm_pkg::cdm_state_s nxt_st;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic ce_reset;
      cdm_pkg::cdm_addr_t m_addr;
      cdm_pkg::cdm_addr_t r_addr;
      cdm_pkg::cdm_addr_t dst;
      cdm_pkg::cdm_nib_t a_val;
      cdm_pkg::cdm_nib_t b_val;
      cdm_pkg::cdm_nib_t res;
      logic [`CDM_NIB_W:0] wide;
      logic carry_in;
      logic do_write;
      logic set_carry;
      logic skip;
      ce_reset = 1'b0;
      m_addr = '0;
      r_addr = '0;
      dst = '0;
      a_val = '0;
      b_val = '0;
      res = '0;
      wide = '0;
      carry_in = 1'b0;
      do_write = 1'b0;
      set_carry = 1'b0;
      skip = 1'b0;
      nxt_st = st_ff;

      // pin synchronisers; ports are looked at in the second stage, the enable in the second and third
      nxt_st.ce_s1 = ce_pin_i;
      nxt_st.ce_s2 = st_ff.ce_s1;
      nxt_st.ce_s3 = st_ff.ce_s2;
      nxt_st.pa_s1 = port_a_pin_i;
      nxt_st.pa_s2 = st_ff.pa_s1;
      nxt_st.pb_s1 = port_b_pin_i;
      nxt_st.pb_s2 = st_ff.pb_s1;
      ce_reset = st_ff.ce_s2 & ~st_ff.ce_s3;

      // ---------------------------------------------------------------
      // program counter and return-address holder
      // ---------------------------------------------------------------
      // the holder has no path from ce_reset or clock_stop_i
      if (ce_reset) begin
         nxt_st.pc = `CDM_PC_RESET;
      end else if (call_i) begin
         nxt_st.ret_addr = st_ff.pc;
         nxt_st.pc = target_addr_i;
      end else if (branch_i) begin
         nxt_st.pc = target_addr_i;
      end else if (return_i) begin
         nxt_st.pc = st_ff.ret_addr;
      end else if (pc_step_i) begin
         nxt_st.pc = st_ff.pc + `CDM_PC_ONE;
      end

      // ---------------------------------------------------------------
      // nibble operation unit
      // ---------------------------------------------------------------
      nxt_st.skip = 1'b0;
      nxt_st.done = exec_i;
      if (exec_i) begin
         m_addr = join_addr(mem_row_i, mem_col_i);
         r_addr = join_addr(`CDM_WREG_ROW, wreg_col_i);
         if (imm_mode_i) begin
            a_val = read_view(st_ff, m_addr);
            b_val = imm_i;
            dst = m_addr;
         end else begin
            a_val = read_view(st_ff, r_addr);
            b_val = read_view(st_ff, m_addr);
            dst = r_addr;
         end
         carry_in = st_ff.mem[`CDM_FLAG_HI][`CDM_FLAG_CY];
         case (op_i)
            cdm_pkg::CDM_OP_ADD, cdm_pkg::CDM_OP_ADD_CY: begin
               wide = {1'b0, a_val} + {1'b0, b_val}
                  + {{`CDM_NIB_W{1'b0}}, carry_in & (op_i == cdm_pkg::CDM_OP_ADD_CY)};
               res = wide[`CDM_NIB_W-1:0];
               do_write = 1'b1;
               set_carry = 1'b1;
            end
            cdm_pkg::CDM_OP_SUB, cdm_pkg::CDM_OP_SUB_BW: begin
               wide = {1'b0, a_val} - {1'b0, b_val}
                  - {{`CDM_NIB_W{1'b0}}, carry_in & (op_i == cdm_pkg::CDM_OP_SUB_BW)};
               res = wide[`CDM_NIB_W-1:0];
               do_write = 1'b1;
               set_carry = 1'b1;
            end
            cdm_pkg::CDM_OP_AND: begin
               res = a_val & b_val;
               do_write = 1'b1;
            end
            cdm_pkg::CDM_OP_OR: begin
               res = a_val | b_val;
               do_write = 1'b1;
            end
            cdm_pkg::CDM_OP_XOR: begin
               res = a_val ^ b_val;
               do_write = 1'b1;
            end
            cdm_pkg::CDM_OP_LOAD: begin
               // immediate form moves the constant into the memory nibble
               res = b_val;
               do_write = 1'b1;
            end
            cdm_pkg::CDM_OP_STORE: begin
               res = a_val;
               dst = m_addr;
               do_write = 1'b1;
            end
            cdm_pkg::CDM_OP_SK_EQ: begin
               res = a_val;
               skip = (a_val == b_val);
            end
            cdm_pkg::CDM_OP_SK_GE: begin
               res = a_val;
               skip = (a_val >= b_val);
            end
            cdm_pkg::CDM_OP_SK_LT: begin
               res = a_val;
               skip = (a_val < b_val);
            end
            cdm_pkg::CDM_OP_SK_NE: begin
               res = a_val;
               skip = (a_val != b_val);
            end
            cdm_pkg::CDM_OP_SK_ALL: begin
               res = a_val;
               skip = ((a_val & b_val) == b_val);
            end
            cdm_pkg::CDM_OP_SK_NONE: begin
               res = a_val;
               skip = ((a_val & b_val) == `CDM_NIB_ZERO);
            end
            default: begin
               res = a_val;
            end
         endcase
         // carry first, so a result aimed at the flag nibble replaces it
         if (set_carry) begin
            nxt_st.mem[`CDM_FLAG_HI][`CDM_FLAG_CY] = wide[`CDM_NIB_W];
         end
         if (do_write) begin
            nxt_st.mem[dst] = write_view(dst, res, nxt_st.mem[dst]);
         end
         nxt_st.result = res;
         nxt_st.skip = skip;
      end

      // ---------------------------------------------------------------
      // transfer buffer and synthesizer ratio
      // ---------------------------------------------------------------
      // buffer nibble 0C carries the most significant four bits
      if (periph_put_i && periph_addr_i == `CDM_PERIPH_SYNTH) begin
         for (int i = 0; i < `CDM_XFER_COUNT; i++) begin
            nxt_st.synth_div[`CDM_SYNTH_W-1-i*`CDM_NIB_W -: `CDM_NIB_W] =
               st_ff.mem[`CDM_XFER_FIRST + i[`CDM_ADDR_W-1:0]];
         end
      end
      // a read-back lands on the buffer after any instruction write
      if (periph_get_i && periph_addr_i == `CDM_PERIPH_SYNTH) begin
         for (int i = 0; i < `CDM_XFER_COUNT; i++) begin
            nxt_st.mem[`CDM_XFER_FIRST + i[`CDM_ADDR_W-1:0]] =
               synth_div_rd_i[`CDM_SYNTH_W-1-i*`CDM_NIB_W -: `CDM_NIB_W];
         end
      end

      // ---------------------------------------------------------------
      // hardware-set judge flags; a set beats a clear in the same cycle
      // ---------------------------------------------------------------
      nxt_st.mem[`CDM_CE_JDG] = {3'b000, st_ff.ce_s2};
      if (synth_unlock_i) begin
         nxt_st.mem[`CDM_UNLK_JDG][`CDM_JDG_BIT] = 1'b1;
      end
      if (btm0_carry_i) begin
         nxt_st.mem[`CDM_BT0_JDG][`CDM_JDG_BIT] = 1'b1;
      end
      if (btm1_carry_i) begin
         nxt_st.mem[`CDM_BT1_JDG][`CDM_JDG_BIT] = 1'b1;
      end

      // flag word is cleared at enable reset and clock stop
      if (ce_reset || clock_stop_i) begin
         nxt_st.mem[`CDM_FLAG_LO] = `CDM_NIB_ZERO;
         nxt_st.mem[`CDM_FLAG_HI] = `CDM_NIB_ZERO;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // the holder is zeroed too, but nothing may rely on that value
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign pc_o = st_ff.pc;
   assign result_o = st_ff.result;
   assign skip_o = st_ff.skip;
   assign done_o = st_ff.done;
   assign display_enable_ctrl_o = st_ff.mem[`CDM_DISP_EN];
   assign synth_mode_ctrl_o = st_ff.mem[`CDM_SYN_MODE];
   assign synth_div_o = st_ff.synth_div;
   assign port_a_data_o = st_ff.mem[`CDM_PORT_A];
   assign port_c_data_o = st_ff.mem[`CDM_PORT_C];
   assign port_d_data_o = st_ff.mem[`CDM_PORT_D][0];
   assign flag_word_high_o = st_ff.mem[`CDM_FLAG_HI];
   assign flag_word_low_o = st_ff.mem[`CDM_FLAG_LO][`CDM_FLAG_BCD];

   // segment_data_8 at 61 sits in the top nibble
   for (genvar g = 0; g < `CDM_SEG_COUNT; g++) begin : g_seg
      assign segment_data_o[g*`CDM_NIB_W +: `CDM_NIB_W] =
         st_ff.mem[`CDM_SEG_LAST - `CDM_ADDR_W'(g)];
   end

endmodule : cdm_core

// >>> bench/cdm_core_sva.sv
/*
 * Concurrent checks on the ports of cdm_core.
 * Assumes one clock domain and a bind from the testbench top file.
 */
module cdm_core_sva (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic branch_i,
   input wire logic call_i,
   input wire logic return_i,
   input wire logic [10:0] target_addr_i,
   input wire logic exec_i,
   input wire cdm_pkg::cdm_op_e op_i,
   input wire logic imm_mode_i,
   input wire logic [2:0] mem_row_i,
   input wire logic [3:0] mem_col_i,
   input wire logic [3:0] imm_i,
   input wire logic periph_put_i,
   input wire logic [6:0] periph_addr_i,
   input wire logic ce_pin_i,
   input wire logic [10:0] pc_o,
   input wire logic [3:0] result_o,
   input wire logic skip_o,
   input wire logic done_o,
   input wire logic [35:0] segment_data_o,
   input wire logic [15:0] synth_div_o,
   input wire logic [3:0] flag_word_high_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------
   // helper logic
   // ----------------
   logic [3:0] ce_hist_ff;
   logic [10:0] held_ff;
   logic held_vld_ff;
   logic ce_quiet;
   logic [6:0] addr;
   assign addr = {mem_row_i, mem_col_i};
   // an enable reset pending in the synchronizer would override the sequencer
   assign ce_quiet = (ce_hist_ff == {4{ce_pin_i}});
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ce_hist_ff <= 4'h0;
         held_ff <= 11'h000;
         held_vld_ff <= 1'b0;
      end else begin
         ce_hist_ff <= {ce_hist_ff[2:0], ce_pin_i};
         if (call_i) begin
            held_ff <= pc_o;
            held_vld_ff <= ce_quiet;
         end
      end
   end
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // ----------------
   // properties
   // ----------------
   property p_call;
      call_i && ce_quiet |=> pc_o == $past(target_addr_i);
   endproperty
   a_call: assert property (p_call) else $error("call target not taken");
   property p_return;
      return_i && !call_i && !branch_i && ce_quiet && held_vld_ff |=> pc_o == $past(held_ff);
   endproperty
   a_return: assert property (p_return) else $error("bad return address");
   property p_ce_reset;
      $rose(ce_pin_i) |-> ##3 (pc_o == 11'h000 && flag_word_high_o == 4'h0);
   endproperty
   a_ce_reset: assert property (p_ce_reset) else $error("enable reset missed");
   property p_flag_bit0;
      exec_i |-> ##[0:2] !flag_word_high_o[0];
   endproperty
   a_flag_bit0: assert property (p_flag_bit0) else $error("flag bit0 set");
   property p_done;
      exec_i |=> done_o;
   endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_no_done;
      !exec_i |=> !done_o && !skip_o;
   endproperty
   a_no_done: assert property (p_no_done) else $error("stray done");
   property p_seg;
      exec_i && imm_mode_i && op_i == cdm_pkg::CDM_OP_LOAD && addr == 7'h61
         |=> segment_data_o[35:32] == $past(imm_i);
   endproperty
   a_seg: assert property (p_seg) else $error("segment not updated");
   property p_sys_zero;
      exec_i && imm_mode_i && op_i == cdm_pkg::CDM_OP_SK_EQ && addr >= 7'h74 && addr <= 7'h7D
         |=> result_o == 4'h0;
   endproperty
   a_sys_zero: assert property (p_sys_zero) else $error("control nibble not zero");
   property p_ratio_hold;
      !(periph_put_i && periph_addr_i == 7'h41) |=> $stable(synth_div_o);
   endproperty
   a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved");
endmodule : cdm_core_sva

// >>> bench/cdm_periph_model.sv
/*
 * Model of the synthesizer data register and the input port pins.
 * Assumes it shares sys_clk_i and rstn_i with cdm_core.
 */
module cdm_periph_model #(
   parameter logic [3:0] PA_LEVEL = 4'h6,
   parameter logic [2:0] PB_LEVEL = 3'h5
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic periph_get_i,
   input wire logic [6:0] periph_addr_i,
   input wire logic [15:0] synth_div_i,
   output logic [15:0] synth_div_rd_o,
   output logic [3:0] port_a_pin_o,
   output logic [2:0] port_b_pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] ratio_ff;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ratio_ff <= 16'h0000;
      end else begin
         ratio_ff <= synth_div_i;
      end
   end
   // unselected bus shows the inverse, so a misplaced read never sees the ratio
   assign synth_div_rd_o = (periph_get_i && periph_addr_i == 7'h41) ? ratio_ff : ~ratio_ff;
   assign port_a_pin_o = PA_LEVEL;
   assign port_b_pin_o = PB_LEVEL;
endmodule : cdm_periph_model

// >>> bench/cdm_core_tb.sv
/*
 * Self-checking testbench of cdm_core with the peripheral model.
 * Assumes package, design, checker and model are compiled first.
 */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cdm_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] PA = 4'h6;
   localparam logic [2:0] PB = 3'h5;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   logic sys_clk_i, rstn_i, pc_step_i, branch_i, call_i, return_i, clock_stop_i, exec_i;
   logic imm_mode_i, periph_put_i, periph_get_i, synth_unlock_i, btm0_carry_i, btm1_carry_i;
   logic ce_pin_i, skip_o, done_o, port_d_data_o, flag_word_low_o;
   logic [10:0] target_addr_i, pc_o;
   cdm_pkg::cdm_op_e op_i;
   logic [2:0] mem_row_i, port_b_pin_i;
   logic [3:0] mem_col_i, wreg_col_i, imm_i, port_a_pin_i, result_o, flag_word_high_o;
   logic [3:0] display_enable_ctrl_o, synth_mode_ctrl_o, port_a_data_o, port_c_data_o;
   logic [6:0] periph_addr_i;
   logic [15:0] synth_div_rd_i, synth_div_o;
   logic [35:0] segment_data_o, seg_e;
   cdm_core cdm_core_inst (.sys_clk_i, .rstn_i, .pc_step_i, .branch_i, .call_i, .return_i,
      .target_addr_i, .clock_stop_i, .exec_i, .op_i, .imm_mode_i, .mem_row_i, .mem_col_i,
      .wreg_col_i, .imm_i, .periph_put_i, .periph_get_i, .periph_addr_i, .synth_div_rd_i,
      .synth_unlock_i, .btm0_carry_i, .btm1_carry_i, .ce_pin_i, .port_a_pin_i, .port_b_pin_i,
      .pc_o, .result_o, .skip_o, .done_o, .segment_data_o, .display_enable_ctrl_o,
      .synth_mode_ctrl_o, .synth_div_o, .port_a_data_o, .port_c_data_o, .port_d_data_o,
      .flag_word_high_o, .flag_word_low_o);
   cdm_periph_model #(.PA_LEVEL(PA), .PB_LEVEL(PB)) cdm_periph_model_inst (.sys_clk_i,
      .rstn_i, .periph_get_i, .periph_addr_i, .synth_div_i(synth_div_o),
      .synth_div_rd_o(synth_div_rd_i), .port_a_pin_o(port_a_pin_i), .port_b_pin_o(port_b_pin_i));
   // ----------------
   // access tasks
   // ----------------
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // k: 0 call, 1 branch, 2 return, 3 clock stop, 4 step
   task automatic seq(input int k, input logic [10:0] t);
      @(posedge sys_clk_i);
      call_i <= (k == 0);
      branch_i <= (k == 1);
      return_i <= (k == 2);
      clock_stop_i <= (k == 3);
      pc_step_i <= (k == 4);
      target_addr_i <= t;
      @(posedge sys_clk_i);
      {call_i, branch_i, return_i, clock_stop_i, pc_step_i} <= 5'h00;
      #1;
   endtask : seq
   task automatic op(input cdm_pkg::cdm_op_e o, input logic im, input logic [6:0] a,
                     input logic [3:0] w, input logic [3:0] v);
      @(posedge sys_clk_i);
      exec_i <= 1'b1;
      op_i <= o;
      imm_mode_i <= im;
      {mem_row_i, mem_col_i} <= a;
      wreg_col_i <= w;
      imm_i <= v;
      @(posedge sys_clk_i);
      exec_i <= 1'b0;
      #1;
      `CHK(done_o, 1'b1)
   endtask : op
   task automatic wr(input logic [6:0] a, input logic [3:0] v);
      op(cdm_pkg::CDM_OP_LOAD, 1'b1, a, 4'h0, v);
   endtask : wr
   // a skip compare reads a nibble, no write
   task automatic rd_chk(input logic [6:0] a, input logic [3:0] e);
      op(cdm_pkg::CDM_OP_SK_EQ, 1'b1, a, 4'h0, 4'h0);
      `CHK(result_o, e)
   endtask : rd_chk
   task automatic periph(input logic put, input logic [6:0] a);
      @(posedge sys_clk_i);
      periph_put_i <= put;
      periph_get_i <= !put;
      periph_addr_i <= a;
      @(posedge sys_clk_i);
      {periph_put_i, periph_get_i} <= 2'h0;
      #1;
   endtask : periph
   // memory nibble 9 against operand 8, with the carry flag preset from f
   task automatic alu(input cdm_pkg::cdm_op_e o, input logic [3:0] f, input logic [3:0] er,
                      input logic es);
      wr(7'h7F, f);
      wr(7'h30, 4'h9);
      op(o, 1'b1, 7'h30, 4'h0, 4'h8);
      `CHK(result_o, er)
      `CHK(skip_o, es)
   endtask : alu
   function automatic logic [3:0] pat(input logic [6:0] a);
      return a[3:0] ^ {1'b0, a[6:4]};
   endfunction : pat
   function automatic logic [3:0] map_exp(input logic [6:0] a, input logic [3:0] v);
      if (a >= 7'h74 && a <= 7'h7D) return 4'h0;
      case (a)
         7'h7F: return {v[3:1], 1'b0};
         7'h71: return {1'b0, PB};
         7'h70: return {v[3:2], PA[1:0]};
         7'h6C: return 4'h1;
         7'h7E, 7'h6D, 7'h6E, 7'h6F, 7'h73: return {3'h0, v[0]};
         default: return v;
      endcase
   endfunction : map_exp
   // ----------------
   // clock, timeout, tests
   // ----------------
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end
   initial begin
      {rstn_i, pc_step_i, branch_i, call_i, return_i, clock_stop_i, exec_i, ce_pin_i} = '0;
      {imm_mode_i, periph_put_i, periph_get_i, synth_unlock_i, btm0_carry_i, btm1_carry_i} = '0;
      op_i = cdm_pkg::CDM_OP_ADD;
      {target_addr_i, mem_row_i, mem_col_i, wreg_col_i, imm_i, periph_addr_i} = '0;
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      seq(1, 11'h123);
      seq(4, 11'h000);
      `CHK(pc_o, 11'h124)
      seq(0, 11'h456);
      `CHK(pc_o, 11'h456)
      seq(0, 11'h500);
      seq(2, 11'h000);
      `CHK(pc_o, 11'h456)
      $display("test program_flow done");
      wr(7'h7F, 4'hE);
      seq(3, 11'h000);
      `CHK(flag_word_high_o, 4'h0)
      @(posedge sys_clk_i);
      ce_pin_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      #1;
      `CHK(pc_o, 11'h000)
      seq(2, 11'h000);
      `CHK(pc_o, 11'h456)
      $display("test holder_retention done");
      for (int i = 0; i < 128; i++) wr(7'(i), pat(7'(i)));
      for (int i = 0; i < 128; i++) rd_chk(7'(i), map_exp(7'(i), pat(7'(i))));
      for (int k = 0; k < 9; k++) seg_e[35 - 4 * k -: 4] = pat(7'(97 + k));
      `CHK(segment_data_o, seg_e)
      `CHK(display_enable_ctrl_o, pat(7'h6A))
      `CHK(synth_mode_ctrl_o, pat(7'h6B))
      `CHK(port_a_data_o, pat(7'h70))
      `CHK(port_c_data_o, pat(7'h72))
      `CHK({3'h0, port_d_data_o}, map_exp(7'h73, pat(7'h73)))
      `CHK(flag_word_high_o, map_exp(7'h7F, pat(7'h7F)))
      `CHK({3'h0, flag_word_low_o}, map_exp(7'h7E, pat(7'h7E)))
      wr(7'h6D, 4'h0);
      rd_chk(7'h6D, 4'h0);
      @(posedge sys_clk_i);
      synth_unlock_i <= 1'b1;
      @(posedge sys_clk_i);
      synth_unlock_i <= 1'b0;
      rd_chk(7'h6D, 4'h1);
      $display("test memory_map done");
      for (int i = 0; i < 4; i++) wr(7'(12 + i), 4'(i + 1));
      periph(1'b1, 7'h41);
      `CHK(synth_div_o, 16'h1234)
      wr(7'h0C, 4'hF);
      periph(1'b1, 7'h40);
      `CHK(synth_div_o, 16'h1234)
      periph(1'b0, 7'h41);
      for (int i = 0; i < 4; i++) rd_chk(7'(12 + i), 4'(i + 1));
      $display("test transfer_buffer done");
      alu(cdm_pkg::CDM_OP_ADD, 4'h0, 4'h1, 1'b0);
      rd_chk(7'h7F, 4'h4);
      alu(cdm_pkg::CDM_OP_ADD_CY, 4'h4, 4'h2, 1'b0);
      alu(cdm_pkg::CDM_OP_SUB, 4'h0, 4'h1, 1'b0);
      alu(cdm_pkg::CDM_OP_SUB_BW, 4'h4, 4'h0, 1'b0);
      alu(cdm_pkg::CDM_OP_AND, 4'h0, 4'h8, 1'b0);
      alu(cdm_pkg::CDM_OP_OR, 4'h0, 4'h9, 1'b0);
      alu(cdm_pkg::CDM_OP_XOR, 4'h0, 4'h1, 1'b0);
      alu(cdm_pkg::CDM_OP_LOAD, 4'h0, 4'h8, 1'b0);
      alu(cdm_pkg::CDM_OP_SK_EQ, 4'h0, 4'h9, 1'b0);
      alu(cdm_pkg::CDM_OP_SK_GE, 4'h0, 4'h9, 1'b1);
      alu(cdm_pkg::CDM_OP_SK_LT, 4'h0, 4'h9, 1'b0);
      alu(cdm_pkg::CDM_OP_SK_NE, 4'h0, 4'h9, 1'b1);
      alu(cdm_pkg::CDM_OP_SK_ALL, 4'h0, 4'h9, 1'b1);
      alu(cdm_pkg::CDM_OP_SK_NONE, 4'h0, 4'h9, 1'b0);
      wr(7'h05, 4'h3);
      wr(7'h45, 4'h4);
      op(cdm_pkg::CDM_OP_ADD, 1'b0, 7'h45, 4'h5, 4'h0);
      `CHK(result_o, 4'h7)
      rd_chk(7'h05, 4'h7);
      op(cdm_pkg::CDM_OP_STORE, 1'b0, 7'h52, 4'h5, 4'h0);
      rd_chk(7'h52, 4'h7);
      $display("test operations done");
      tally_and_finish();
   end
endmodule : cdm_core_tb
bind cdm_core cdm_core_sva cdm_core_sva_inst (.sys_clk_i, .rstn_i, .branch_i, .call_i,
   .return_i, .target_addr_i, .exec_i, .op_i, .imm_mode_i, .mem_row_i, .mem_col_i, .imm_i,
   .periph_put_i, .periph_addr_i, .ce_pin_i, .pc_o, .result_o, .skip_o, .done_o,
   .segment_data_o, .synth_div_o, .flag_word_high_o);
